// ==== logic/tsm_sequencer.sv ====
// Mode sequencer of the termination supply with an AXI4-Lite register port
// Functional notes
// - Run mode only with supply in range, both requests high, no fault.
// - Suspend low: standby, termination high impedance, reference on, converter off.
// - Power-off low: shutdown, all outputs off and discharged.
// - Discharge switches on only in shutdown.
// - Internal core supply and its reset supervisor off in shutdown.
// - Power-up with power-off asserted: nothing enabled, no ramp.
// - Power-up in standby: only core supply, bias and reference come up.
// - On release: drop internal reset, enable blocks, sample rate select.
// - After enabling, run a soft start toward regulation.
// - Soft start on every exit from standby, shutdown, recycle, retry.
// - Started without fault and in regulation: wait 10 ms, drive power-good low.
// - On a fault, release the open-drain power-good.
// - Control merges monitor alerts and requests into up/down commands.
// - Overcurrent, short, temperature, over/undervoltage monitors alert control.
// - Oscillator clocks logic; rate defaults to 1.0 MHz unless selected.
// - Over/undervoltage counted after 20 us; power-good only, outputs stay on.
// - Current limit 10 ms persistent: output off, retry after 100 ms.
// - Short circuit: output off at once, retry after 100 ms.
// - Over temperature: off until cooled, then 100 ms, then soft start.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tsm_sequencer #(
	parameter logic [tsm_pkg::TIMER_W-1:0] PG_DELAY_CYC = tsm_pkg::TIMER_W'(tsm_pkg::PG_DELAY_CYC),
	parameter logic [tsm_pkg::TIMER_W-1:0] RETRY_CYC = tsm_pkg::TIMER_W'(tsm_pkg::RETRY_CYC),
	parameter logic [tsm_pkg::TIMER_W-1:0] OC_LIMIT_CYC = tsm_pkg::TIMER_W'(tsm_pkg::OC_LIMIT_CYC)
) (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Host request pins
	input wire logic suspend_request_n_in,
	input wire logic power_off_request_n_in,
	output logic supply_ok_n_out,
	output logic supply_ok_n_oe_out,
	// Monitors
	input wire logic vin_ok_in,
	input wire logic at_regulation_in,
	input wire logic over_current_in,
	input wire logic short_circuit_in,
	input wire logic over_temp_in,
	input wire logic over_voltage_in,
	input wire logic under_voltage_in,
	input wire logic [tsm_pkg::RATE_W-1:0] switch_rate_select_in,
	// Power stage commands
	output logic internal_core_supply_en_out,
	output logic bias_en_out,
	output logic por_release_out,
	output logic converter_en_out,
	output logic soft_start_out,
	output logic termination_hiz_out,
	output logic reference_en_out,
	output logic discharge_en_out,
	output logic [tsm_pkg::RATE_W-1:0] switch_rate_out,
	// AXI4-Lite slave
	input wire logic [tsm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tsm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int SYNC_W = 9 + tsm_pkg::RATE_W;

	function automatic logic reg_known(input logic [tsm_pkg::ADDR_W-1:0] a);
		reg_known = (a == tsm_pkg::ADDR_CTRL) || (a == tsm_pkg::ADDR_STATUS) ||
			(a == tsm_pkg::ADDR_FAULT) || (a == tsm_pkg::ADDR_RATE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync1_next;
	logic [SYNC_W-1:0] sync2_next;
	logic sd_n_s, suspend_request_n_n_s, vin_s, reg_s, oc_s, short_s, ot_s, ov_s, uv_s;
	logic [tsm_pkg::RATE_W-1:0] rate_s;

	always_comb begin
		sync1_next = sync1_reg;
		sync2_next = sync2_reg;
		if (ce_in) begin
			sync1_next = {switch_rate_select_in, under_voltage_in, over_voltage_in, over_temp_in,
				short_circuit_in, over_current_in, at_regulation_in, vin_ok_in,
				suspend_request_n_in, power_off_request_n_in};
			sync2_next = sync1_reg;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	assign {rate_s, uv_s, ov_s, ot_s, short_s, oc_s, reg_s, vin_s, suspend_request_n_n_s, sd_n_s} = sync2_reg;

	////////////////////////////////////////////////////////////////////////////
	// Monitor filters
	logic oc_expired;
	logic ovuv_fault;

	tsm_persist_filter #(.CNT_W(tsm_pkg::TIMER_W), .LIMIT(OC_LIMIT_CYC)) u_oc_timer (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.level_in(oc_s && converter_en_out),
		.expired_out(oc_expired)
	);

	tsm_persist_filter #(.CNT_W(tsm_pkg::TIMER_W), .LIMIT(tsm_pkg::TIMER_W'(tsm_pkg::OVUV_FILTER_CYC)))
		u_ovuv_filter (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.level_in(ov_s || uv_s),
		.expired_out(ovuv_fault)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	tsm_pkg::tsm_state_t state_reg, state_next;
	logic [tsm_pkg::TIMER_W-1:0] timer_reg, timer_next;
	logic [tsm_pkg::RATE_W-1:0] rate_reg, rate_next;
	logic pg_reg, pg_next;
	logic [1:0] ctrl_reg, ctrl_next;
	logic hard_fault, enabled_req;

	assign hard_fault = oc_expired || short_s || ot_s;
	assign enabled_req = sd_n_s && suspend_request_n_n_s && vin_s && !ctrl_reg[tsm_pkg::CTRL_SUSPEND_REQUEST_N_BIT];

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		rate_next = rate_reg;
		pg_next = 1'b0;
		if (ce_in) begin
			if (!sd_n_s) begin
				state_next = tsm_pkg::ST_OFF;
			end else if (!enabled_req) begin
				state_next = tsm_pkg::ST_STANDBY;
			end else begin
				case (state_reg)
					tsm_pkg::ST_OFF, tsm_pkg::ST_STANDBY: begin
						state_next = tsm_pkg::ST_POR_REL;
					end
					tsm_pkg::ST_POR_REL: begin
						rate_next = rate_s;
						state_next = tsm_pkg::ST_SOFT_START;
					end
					tsm_pkg::ST_SOFT_START: begin
						if (hard_fault) begin
							state_next = tsm_pkg::ST_FAULT_WAIT;
						end else if (reg_s) begin
							state_next = tsm_pkg::ST_RUN;
						end
					end
					tsm_pkg::ST_RUN: begin
						if (hard_fault) begin
							state_next = tsm_pkg::ST_FAULT_WAIT;
						end else begin
							if (timer_reg < PG_DELAY_CYC) begin
								timer_next = timer_reg + 1'b1;
							end
							pg_next = (timer_reg >= PG_DELAY_CYC) && !ovuv_fault;
						end
					end
					tsm_pkg::ST_FAULT_WAIT: begin
						if (ot_s) begin
							timer_next = '0;
						end else if (timer_reg < RETRY_CYC - 1'b1) begin
							timer_next = timer_reg + 1'b1;
						end else if (!ctrl_reg[tsm_pkg::CTRL_NORETRY_BIT]) begin
							state_next = tsm_pkg::ST_SOFT_START;
						end
					end
					default: begin
						state_next = tsm_pkg::ST_OFF;
					end
				endcase
			end
			if (state_next != state_reg) begin
				timer_next = '0;
			end
		end else begin
			pg_next = pg_reg;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= tsm_pkg::ST_OFF;
			timer_reg <= '0;
			rate_reg <= tsm_pkg::RATE_RST;
			pg_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			rate_reg <= rate_next;
			pg_reg <= pg_next;
		end
	end

	assign internal_core_supply_en_out = (state_reg != tsm_pkg::ST_OFF);
	assign bias_en_out = (state_reg != tsm_pkg::ST_OFF);
	assign por_release_out = (state_reg >= tsm_pkg::ST_POR_REL);
	assign converter_en_out = (state_reg == tsm_pkg::ST_SOFT_START) || (state_reg == tsm_pkg::ST_RUN);
	assign soft_start_out = (state_reg == tsm_pkg::ST_SOFT_START);
	assign termination_hiz_out = !converter_en_out;
	assign reference_en_out = (state_reg != tsm_pkg::ST_OFF);
	assign discharge_en_out = (state_reg == tsm_pkg::ST_OFF);
	assign switch_rate_out = rate_reg;
	assign supply_ok_n_out = 1'b0;
	assign supply_ok_n_oe_out = pg_reg;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave and registers
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [tsm_pkg::ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [tsm_pkg::FAULT_W-1:0] fault_reg, fault_next, fault_set;

	assign s_axi_awready = ce_in && !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = ce_in && !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = ce_in && !rvalid_reg;
	assign fault_set = {ovuv_fault && (state_reg == tsm_pkg::ST_RUN), ot_s, short_s, oc_expired};

	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		fault_next = fault_reg;
		if (ce_in) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_next = 1'b1;
				awaddr_next = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_next = 1'b1;
				wdata_next = s_axi_wdata;
				wstrb0_next = s_axi_wstrb[0];
			end
			if (aw_hold_reg && w_hold_reg) begin
				aw_hold_next = 1'b0;
				w_hold_next = 1'b0;
				bvalid_next = 1'b1;
				bresp_next = reg_known(awaddr_reg) ? tsm_pkg::RESP_OKAY : tsm_pkg::RESP_SLVERR;
				if (wstrb0_reg && awaddr_reg == tsm_pkg::ADDR_CTRL) begin
					ctrl_next = wdata_reg[1:0];
				end
				if (wstrb0_reg && awaddr_reg == tsm_pkg::ADDR_FAULT) begin
					fault_next = fault_reg & ~wdata_reg[tsm_pkg::FAULT_W-1:0];
				end
			end else if (s_axi_bready) begin
				bvalid_next = 1'b0;
			end
			// Set beats a same-cycle clear
			fault_next = fault_next | fault_set;
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_next = 1'b1;
				rresp_next = reg_known(s_axi_araddr) ? tsm_pkg::RESP_OKAY : tsm_pkg::RESP_SLVERR;
				case (s_axi_araddr)
					tsm_pkg::ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
					tsm_pkg::ADDR_STATUS: rdata_next = {25'h000_0000, discharge_en_out, converter_en_out,
						pg_reg, 1'b0, state_reg};
					tsm_pkg::ADDR_FAULT: rdata_next = {28'h000_0000, fault_reg};
					tsm_pkg::ADDR_RATE: rdata_next = {28'h000_0000, rate_reg};
					default: rdata_next = 32'h0000_0000;
				endcase
			end else if (s_axi_rready) begin
				rvalid_next = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= tsm_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= tsm_pkg::RESP_OKAY;
			rdata_reg <= '0;
			ctrl_reg <= tsm_pkg::CTRL_RST;
			fault_reg <= tsm_pkg::FAULT_RST;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			fault_reg <= fault_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sd_precedence_a: assert property (ce_in && !sd_n_s |=> state_reg == tsm_pkg::ST_OFF)
		else $error("power-off request did not force shutdown");
	standby_enter_a: assert property (ce_in && sd_n_s && !suspend_request_n_n_s |=> state_reg == tsm_pkg::ST_STANDBY)
		else $error("suspend request did not enter standby");
	standby_outputs_a: assert property (state_reg == tsm_pkg::ST_STANDBY |->
		termination_hiz_out && reference_en_out && !converter_en_out && !discharge_en_out)
		else $error("standby outputs wrong");
	discharge_core_a: assert property (discharge_en_out |-> !internal_core_supply_en_out && !reference_en_out)
		else $error("discharge outside shutdown");
	run_needs_req_a: assert property (state_reg == tsm_pkg::ST_RUN |-> $past(enabled_req))
		else $error("run mode without both requests high");
	rate_sample_a: assert property (ce_in && state_reg == tsm_pkg::ST_POR_REL && enabled_req |=>
		state_reg == tsm_pkg::ST_SOFT_START && rate_reg == $past(rate_s))
		else $error("rate not sampled before soft start");
	soft_first_a: assert property ($changed(state_reg) && state_reg == tsm_pkg::ST_RUN |->
		$past(state_reg) == tsm_pkg::ST_SOFT_START)
		else $error("run entered without soft start");
	pg_delay_a: assert property (pg_reg |-> state_reg == tsm_pkg::ST_RUN && timer_reg == PG_DELAY_CYC)
		else $error("power-good driven before reset delay");
	fault_release_a: assert property (ce_in && hard_fault && converter_en_out |=>
		!supply_ok_n_oe_out && !converter_en_out)
		else $error("fault did not release power-good");
	fault_sticky_a: assert property (ce_in && fault_set[tsm_pkg::FAULT_SHORT_BIT] |=>
		fault_reg[tsm_pkg::FAULT_SHORT_BIT])
		else $error("short alert lost");

	run_c: cover property (state_reg == tsm_pkg::ST_RUN);
	pg_c: cover property (pg_reg);
	retry_c: cover property (state_reg == tsm_pkg::ST_FAULT_WAIT ##1 state_reg == tsm_pkg::ST_SOFT_START);
	off_c: cover property (state_reg == tsm_pkg::ST_RUN ##1 state_reg == tsm_pkg::ST_OFF);
endmodule // tsm_sequencer
`default_nettype wire

// ==== logic/tsm_pkg.sv ====
// Shared constants and types of the termination supply mode sequencer
package tsm_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_PG_DELAY_US = 10000;
	localparam int T_RETRY_US = 100000;
	localparam int T_OC_LIMIT_US = 10000;
	localparam int T_OVUV_FILTER_NS = 20000;
	localparam int PG_DELAY_CYC = T_PG_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int RETRY_CYC = T_RETRY_US * 1000 / CLK_PERIOD_NS;
	localparam int OC_LIMIT_CYC = T_OC_LIMIT_US * 1000 / CLK_PERIOD_NS;
	localparam int OVUV_FILTER_CYC = T_OVUV_FILTER_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;
	localparam int RATE_W = 4;

	// Register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_FAULT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_RATE = 8'h0C;

	// Field positions
	localparam int CTRL_SUSPEND_REQUEST_N_BIT = 0;
	localparam int CTRL_NORETRY_BIT = 1;
	localparam int STATUS_PG_BIT = 4;
	localparam int STATUS_CONV_BIT = 5;
	localparam int STATUS_DISCH_BIT = 6;
	localparam int FAULT_OC_BIT = 0;
	localparam int FAULT_SHORT_BIT = 1;
	localparam int FAULT_OT_BIT = 2;
	localparam int FAULT_OVUV_BIT = 3;
	localparam int FAULT_W = 4;

	// Reset values and bus answers
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [FAULT_W-1:0] FAULT_RST = 4'h0;
	localparam logic [RATE_W-1:0] RATE_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_STANDBY = 3'b001,
		ST_POR_REL = 3'b010,
		ST_SOFT_START = 3'b011,
		ST_RUN = 3'b100,
		ST_FAULT_WAIT = 3'b101
	} tsm_state_t;
endpackage

// ==== logic/tsm_persist_filter.sv ====
// Persistence filter: output rises once the input has held for LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module tsm_persist_filter #(
	parameter int CNT_W = 24,
	parameter logic [CNT_W-1:0] LIMIT = 24'h00_0001
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Condition
	input wire logic level_in,
	output logic expired_out
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic expired_reg;
	logic expired_next;

	always_comb begin
		cnt_next = cnt_reg;
		expired_next = expired_reg;
		if (ce_in) begin
			// Any gap in the condition restarts the wait
			if (!level_in) begin
				cnt_next = '0;
				expired_next = 1'b0;
			end else if (cnt_reg < LIMIT - 1'b1) begin
				cnt_next = cnt_reg + 1'b1;
			end else begin
				expired_next = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
			expired_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			expired_reg <= expired_next;
		end
	end

	assign expired_out = expired_reg;
endmodule // tsm_persist_filter
`default_nettype wire

// ==== verification/tsm_host_model.sv ====
// Host power management model: request pins, memory supply and power-good pull-up
`timescale 1ns/1ps
`default_nettype none
module tsm_host_model (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Bench commands, high = release the request
	input wire logic run_cmd_in,
	input wire logic on_cmd_in,
	// Device pins
	input wire logic supply_ok_n_in,
	input wire logic supply_ok_n_oe_in,
	output logic suspend_request_n_out,
	output logic power_off_request_n_out,
	output logic memory_io_supply_on_out,
	output logic supply_ok_pin_out
);
	logic mem_reg;
	logic mem_next;
	logic susp_reg;
	logic susp_next;
	logic off_reg;
	logic off_next;
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		mem_next = mem_reg | on_cmd_in;
		susp_next = run_cmd_in & mem_reg;
		off_next = on_cmd_in & mem_reg;
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_reg <= 1'b0;
			susp_reg <= 1'b0;
			off_reg <= 1'b0;
		end else begin
			mem_reg <= mem_next;
			susp_reg <= susp_next;
			off_reg <= off_next;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	assign suspend_request_n_out = susp_reg;
	assign power_off_request_n_out = off_reg;
	assign memory_io_supply_on_out = mem_reg;
	// Released pin floats to the external pull-up
	assign supply_ok_pin_out = supply_ok_n_oe_in ? supply_ok_n_in : 1'b1;
endmodule // tsm_host_model
`default_nettype wire

// ==== verification/test_tsm_sequencer.sv ====
// Self-checking testbench of the termination supply mode sequencer
`timescale 1ns/1ps
`default_nettype none
module test_tsm_sequencer;
	logic clk, rst_n, ce, run_c, on_c, vin, reg_ok, oc, sc, ot, ov, uv;
	logic [3:0] rsel, rate;
	logic sp_n, off_n, mem_on, pin, ok_n, oe, core, bias, por, conv, ss, hiz, refe, dis;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [33:0] rq[$], bq[$];
	integer seed, fails, checks, cyc, i;
	logic [3:0] r;
	////////////////////////////////////////////////////////////////////////////////
	tsm_sequencer #(.PG_DELAY_CYC(24'h00_0014), .RETRY_CYC(24'h00_001e), .OC_LIMIT_CYC(24'h00_000a)) i_tsm_sequencer (
		.sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .suspend_request_n_in(sp_n),
		.power_off_request_n_in(off_n), .supply_ok_n_out(ok_n), .supply_ok_n_oe_out(oe),
		.vin_ok_in(vin), .at_regulation_in(reg_ok), .over_current_in(oc), .short_circuit_in(sc),
		.over_temp_in(ot), .over_voltage_in(ov), .under_voltage_in(uv), .switch_rate_select_in(rsel),
		.internal_core_supply_en_out(core), .bias_en_out(bias), .por_release_out(por),
		.converter_en_out(conv), .soft_start_out(ss), .termination_hiz_out(hiz), .reference_en_out(refe),
		.discharge_en_out(dis), .switch_rate_out(rate), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tsm_host_model i_tsm_host_model (.sys_clk_in(clk), .rst_n_in(rst_n), .run_cmd_in(run_c),
		.on_cmd_in(on_c), .supply_ok_n_in(ok_n), .supply_ok_n_oe_in(oe), .suspend_request_n_out(sp_n),
		.power_off_request_n_out(off_n), .memory_io_supply_on_out(mem_on), .supply_ok_pin_out(pin));
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp_bus(input string n, input logic [33:0] e, input logic [33:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_pin(input logic [9:0] e);
		// Look between edges, where the outputs have settled
		@(negedge clk);
		checks++;
		if ({pin, core, bias, por, conv, ss, hiz, refe, dis, oe} !== e) begin
			fails++;
			$display("mismatch pins expected %h seen %h", e, {pin, core, bias, por, conv, ss, hiz, refe, dis, oe});
		end
		@(posedge clk);
	endtask
	task automatic cyc_n(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		@(posedge clk);
		bq.push_back({er, 32'h0000_0000});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end while (!hb);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hr;
		@(posedge clk);
		rq.push_back({er, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ha = arvalid && arready;
			hr = rvalid;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end while (!hr);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watcher sees handshakes half a cycle early, inputs only move at rising edges
	always @(negedge clk) begin
		if (rvalid && rready) cmp_bus("read", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) cmp_bus("bresp", bq.pop_front(), {bresp, 32'h0000_0000});
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		seed = 32'h19a6;
		fails = 0;
		checks = 0;
		cyc = 0;
		{rst_n, run_c, on_c, reg_ok, oc, sc, ot, ov, uv, awvalid, wvalid, bready, arvalid, rready} <= '0;
		vin <= 1'b1;
		ce <= 1'b1;
		rsel <= 4'h0;
		{awaddr, araddr, wdata} <= '0;
		cyc_n(10);
		rst_n <= 1'b1;
		cyc_n(8);
		cmp_pin(10'h20a);
		axr(8'h04, 32'h0000_0040, 2'b00);
		axr(8'h00, 32'h0000_0000, 2'b00);
		axr(8'h08, 32'h0000_0000, 2'b00);
		axr(8'h0c, 32'h0000_0000, 2'b00);
		on_c <= 1'b1;
		cyc_n(8);
		cmp_pin(10'h38c);
		axr(8'h04, 32'h0000_0001, 2'b00);
		r = 4'($random(seed));
		rsel <= r;
		run_c <= 1'b1;
		cyc_n(8);
		axr(8'h04, 32'h0000_0023, 2'b00);
		axr(8'h0c, {28'h000_0000, r}, 2'b00);
		@(negedge clk);
		cmp_bus("rate", {30'h0000_0000, r}, {30'h0000_0000, rate});
		cmp_bus("memory supply", 34'h0_0000_0001, {33'h0_0000_0000, mem_on});
		@(posedge clk);
		reg_ok <= 1'b1;
		cyc_n(12);
		cmp_pin(10'h3e4);
		cyc_n(30);
		cmp_pin(10'h1e5);
		axr(8'h04, 32'h0000_0034, 2'b00);
		// Hard faults: overcurrent, short, over temperature
		for (i = 0; i < 3; i++) begin
			{ot, sc, oc} <= 3'(1 << i);
			cyc_n(12 + ($unsigned($random(seed)) % 8));
			{ot, sc, oc} <= 3'h0;
			cyc_n(4);
			cmp_pin(10'h3cc);
			axr(8'h04, 32'h0000_0005, 2'b00);
			axr(8'h08, 32'(1 << i), 2'b00);
			axw(8'h08, 32'(1 << i), 2'b00);
			axr(8'h08, 32'h0000_0000, 2'b00);
			cyc_n(90);
			cmp_pin(10'h1e5);
		end
		// Over and under voltage must persist through the filter
		for (i = 0; i < 2; i++) begin
			{uv, ov} <= 2'(1 << i);
			cyc_n(2400);
			cmp_pin(10'h1e5);
			cyc_n(200);
			cmp_pin(10'h3e4);
			axr(8'h08, 32'h0000_0008, 2'b00);
			{uv, ov} <= 2'h0;
			// Clear only once the filter has dropped, else the set wins
			cyc_n(4);
			axw(8'h08, 32'h0000_0008, 2'b00);
			axr(8'h08, 32'h0000_0000, 2'b00);
			cyc_n(10);
			cmp_pin(10'h1e5);
		end
		// Frozen clock enable must ignore a short alert
		ce <= 1'b0;
		sc <= 1'b1;
		cyc_n(8);
		cmp_pin(10'h1e5);
		{ce, sc} <= 2'b10;
		vin <= 1'b0;
		cyc_n(8);
		cmp_pin(10'h38c);
		vin <= 1'b1;
		cyc_n(60);
		axw(8'h00, 32'h0000_0001, 2'b00);
		cyc_n(6);
		cmp_pin(10'h38c);
		axw(8'h00, 32'h0000_0000, 2'b00);
		axw(8'h14, 32'h0000_0001, 2'b10);
		axr(8'h10, 32'h0000_0000, 2'b10);
		{run_c, on_c} <= 2'b00;
		cyc_n(8);
		cmp_pin(10'h20a);
		axr(8'h04, 32'h0000_0040, 2'b00);
		cyc_n(4);
		summarize();
	end
endmodule // test_tsm_sequencer
`default_nettype wire
